//--- logic/scrb_config_bank.sv
// module: lockable configuration register bank on a classic wishbone slave
// Functional notes
// - upper sensor nibble picks adc current, 10..160 uA ladder, saturates, resets zero.
// - lower sensor nibble picks open-load current, same ladder, resets zero.
// - all configuration registers except the lock register ignore software writes while the lock bit is one.
// - key-off delay bits 6:5 give 100/200/400/800 ms, reset 00.
// - off-timer source bit 4: zero key falling edge, one start command.
// - operation bit 3 chooses afterrun reset, resets to one.
// - operation bit 2 enables afterrun mode, resets to zero.
// - power-down time bits 1:0 give 100..400 ms, reset 01.
// - divider bits 7:5 map to 64,4,8,16,32,64,128,256, reset 101.
// - link bit 4 picks open drain (0) or push-pull (1), reset 0.
// - address mode bit 3: increment A2..A3 per read, or fixed address.
// - parity bit 2: zero odd, one even, reset one.
// - format bits 1:0: 00 no address, else address frames, reset 00.
// - fixed upstream address bits 7:4 of second link register, reset 0000.
// - second link bit 3 enables transmit timeout, reset one.
// - lin mode bits 2:1: 00/11 receive only, 01 link, 10 flash.
// - second link bit 0: zero can receive only, one high speed.
// - 16-bit off-timer threshold split into low and high byte, reset zero.
// - input 9 field bits 4:0, codes 0..3 select outputs 5..8.
// - input 9 codes continue by one per output up to code 10011.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module scrb_config_bank
  import scrb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic      [7:0]  sensor_adc_current_ua_o,
  output logic      [7:0]  sensor_openload_current_ua_o,
  output logic      [1:0]  key_off_delay_sel_o,
  output logic             off_timer_start_source_o,
  output logic             afterrun_reset_sel_o,
  output logic             afterrun_enable_o,
  output logic      [1:0]  power_down_time_sel_o,
  output logic      [8:0]  upstream_divide_ratio_o,
  output logic             serial_out_push_pull_o,
  output logic             upstream_address_mode_o,
  output logic             upstream_even_parity_o,
  output logic             upstream_with_address_o,
  output logic      [3:0]  upstream_fixed_address_o,
  output logic             tx_timeout_enable_o,
  output logic      [1:0]  lin_mode_o,
  output logic             can_high_speed_o,
  output logic      [15:0] off_timer_threshold_o,
  output logic      [4:0]  input9_output_select_o,
  output logic      [4:0]  input9_output_number_o,
  output logic             input9_select_valid_o,
  output logic             lock_o
);

  // ==========================================================
  // decode helpers
  // current ladder in uA: 10 uA steps, then 20 uA steps, saturating
  function automatic logic [7:0] cur_ua(input logic [3:0] code);
    logic [7:0] c;
    c = {4'h0, code};
    if (code > CUR_SAT_CODE)
      cur_ua = CUR_SAT_UA;
    else if (code[3])
      cur_ua = 8'(CUR_HI_BASE + CUR_HI_STEP * {5'h0, code[2:0]});
    else
      cur_ua = 8'(CUR_STEP_UA * (c + 8'h01));
  endfunction : cur_ua

  // masked byte write respecting reserved bits
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] d,
                                         input logic [7:0] m);
    wr_byte = (d & m) | (old & ~m);
  endfunction : wr_byte

  // ==========================================================
  // registers
  logic [7:0] sensor_current_config;
  logic [7:0] operation_config;
  logic [7:0] link_config_a;
  logic [7:0] link_config_b;
  logic [7:0] off_timer_threshold_low;
  logic [7:0] off_timer_threshold_high;
  logic [7:0] input9_assignment;
  logic       lock;

  logic [9:0] idx;
  logic       req;
  logic       hit;
  logic       wr_ok;
  logic [7:0] next_rdata;

  assign idx   = wb_adr_i[11:IDX_SHIFT];
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  // lock blocks every config write but not the lock register itself
  assign wr_ok = req && hit && wb_we_i && wb_sel_i[0] && !lock;

  // address decode and read mux
  always_comb begin
    hit        = 1'b1;
    next_rdata = 8'h00;
    case (idx)
      IDX_SENSOR: next_rdata = sensor_current_config;
      IDX_OPER:   next_rdata = operation_config;
      IDX_LINK_A: next_rdata = link_config_a;
      IDX_LINK_B: next_rdata = link_config_b;
      IDX_THR_LO: next_rdata = off_timer_threshold_low;
      IDX_THR_HI: next_rdata = off_timer_threshold_high;
      IDX_IN9:    next_rdata = input9_assignment;
      IDX_LOCK:   next_rdata = {7'h00, lock};
      default:    hit = 1'b0;
    endcase
  end

  // ==========================================================
  // bus answer: ack one cycle after request, err for unmapped address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      if (req && hit && !wb_we_i)
        wb_dat_o <= {24'h00_0000, next_rdata};
    end
  end

  // lock bit, always writable
  always_ff @(posedge clk_i) begin
    if (rst_i)
      lock <= 1'b0;
    else if (req && wb_we_i && wb_sel_i[0] && idx == IDX_LOCK)
      lock <= wb_dat_i[0];
  end

  // sensor current register
  always_ff @(posedge clk_i) begin
    if (rst_i)
      sensor_current_config <= RST_SENSOR;
    else if (wr_ok && idx == IDX_SENSOR)
      sensor_current_config <= wb_dat_i[7:0];
  end

  // operation register, bit 7 reserved
  always_ff @(posedge clk_i) begin
    if (rst_i)
      operation_config <= RST_OPER;
    else if (wr_ok && idx == IDX_OPER)
      operation_config <= wr_byte(operation_config, wb_dat_i[7:0], MASK_OPER);
  end

  // link registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_config_a <= RST_LINK_A;
      link_config_b <= RST_LINK_B;
    end else begin
      if (wr_ok && idx == IDX_LINK_A)
        link_config_a <= wb_dat_i[7:0];
      if (wr_ok && idx == IDX_LINK_B)
        link_config_b <= wb_dat_i[7:0];
    end
  end

  // threshold bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_timer_threshold_low  <= RST_THR;
      off_timer_threshold_high <= RST_THR;
    end else begin
      if (wr_ok && idx == IDX_THR_LO)
        off_timer_threshold_low <= wb_dat_i[7:0];
      if (wr_ok && idx == IDX_THR_HI)
        off_timer_threshold_high <= wb_dat_i[7:0];
    end
  end

  // input 9 assignment, bits 7:5 reserved
  always_ff @(posedge clk_i) begin
    if (rst_i)
      input9_assignment <= RST_IN9;
    else if (wr_ok && idx == IDX_IN9)
      input9_assignment <= wr_byte(input9_assignment, wb_dat_i[7:0], MASK_IN9);
  end

  // ==========================================================
  // decoded settings toward the consumers
  always_comb begin
    case (link_config_a[DIV_HI:DIV_LO])
      3'h1:    upstream_divide_ratio_o = 9'h004;
      3'h2:    upstream_divide_ratio_o = 9'h008;
      3'h3:    upstream_divide_ratio_o = 9'h010;
      3'h4:    upstream_divide_ratio_o = 9'h020;
      3'h6:    upstream_divide_ratio_o = 9'h080;
      3'h7:    upstream_divide_ratio_o = 9'h100;
      default: upstream_divide_ratio_o = 9'h040;
    endcase
  end

  // lin mode: codes 00 and 11 both mean receive only
  always_comb begin
    case (link_config_b[LIN_HI:LIN_LO])
      LIN_LINK:  lin_mode_o = SCRB_LIN_KLINE;
      LIN_FLASH: lin_mode_o = SCRB_LIN_FLASH;
      default:   lin_mode_o = SCRB_LIN_RX_ONLY;
    endcase
  end

  assign sensor_adc_current_ua_o      = cur_ua(sensor_current_config[ADC_HI:ADC_LO]);
  assign sensor_openload_current_ua_o = cur_ua(sensor_current_config[OL_HI:OL_LO]);
  assign key_off_delay_sel_o      = operation_config[KDL_HI:KDL_LO];
  assign off_timer_start_source_o = operation_config[SRC_B];
  assign afterrun_reset_sel_o     = operation_config[ARS_B];
  assign afterrun_enable_o        = operation_config[ARE_B];
  assign power_down_time_sel_o    = operation_config[PWD_HI:PWD_LO];
  assign serial_out_push_pull_o   = link_config_a[DRV_B];
  assign upstream_address_mode_o  = link_config_a[ADM_B];
  assign upstream_even_parity_o   = link_config_a[PAR_B];
  assign upstream_with_address_o  = link_config_a[FMT_HI:FMT_LO] != FMT_NO_ADDR;
  assign upstream_fixed_address_o = link_config_b[FA_HI:FA_LO];
  assign tx_timeout_enable_o      = link_config_b[TOE_B];
  assign can_high_speed_o         = link_config_b[CAN_B];
  assign off_timer_threshold_o    = {off_timer_threshold_high, off_timer_threshold_low};
  assign input9_output_select_o   = input9_assignment[IN9_HI:0];
  // output number is code plus five, valid up to the last code
  assign input9_select_valid_o    = input9_output_select_o <= IN9_MAX_CODE;
  assign input9_output_number_o   = input9_select_valid_o ?
                                    5'(input9_output_select_o + IN9_FIRST) : 5'h00;
  assign lock_o                   = lock;

  // ==========================================================
  // checks
  property p_lock_freeze;
    @(posedge clk_i) disable iff (rst_i)
      lock ##1 (lock && $stable(lock)) |-> $stable(operation_config) && $stable(link_config_a);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("config changed while locked");

  property p_lock_thr;
    @(posedge clk_i) disable iff (rst_i)
      lock |=> $stable(off_timer_threshold_o) && $stable(input9_assignment) && $stable(sensor_current_config);
  endproperty
  a_lock_thr: assert property (p_lock_thr) else $error("threshold changed while locked");

  property p_write_lands;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ok && idx == IDX_THR_HI) |=> off_timer_threshold_o[15:8] == $past(wb_dat_i[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("threshold high write lost");

  property p_oper_reserved;
    @(posedge clk_i) disable iff (rst_i)
      ##1 !operation_config[7] && input9_assignment[7:5] == 3'h0;
  endproperty
  a_oper_reserved: assert property (p_oper_reserved) else $error("reserved bit set");

  property p_adc_sat;
    @(posedge clk_i) disable iff (rst_i)
      sensor_current_config[ADC_HI:ADC_LO] >= CUR_SAT_CODE |-> sensor_adc_current_ua_o == CUR_SAT_UA;
  endproperty
  a_adc_sat: assert property (p_adc_sat) else $error("adc current not saturated");

  property p_ol_low;
    @(posedge clk_i) disable iff (rst_i)
      sensor_current_config[OL_HI:OL_LO] == 4'h0 |-> sensor_openload_current_ua_o == CUR_STEP_UA;
  endproperty
  a_ol_low: assert property (p_ol_low) else $error("open-load current code zero wrong");

  property p_div_reset;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> upstream_divide_ratio_o == 9'h040 && upstream_even_parity_o && !upstream_with_address_o;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("link reset value wrong");

  property p_lin_reset;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> lin_mode_o == SCRB_LIN_FLASH && tx_timeout_enable_o && can_high_speed_o;
  endproperty
  a_lin_reset: assert property (p_lin_reset) else $error("second link reset value wrong");

  property p_oper_reset;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> power_down_time_sel_o == 2'h1 && afterrun_reset_sel_o && !afterrun_enable_o;
  endproperty
  a_oper_reset: assert property (p_oper_reset) else $error("operation reset value wrong");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_in9_num;
    @(posedge clk_i) disable iff (rst_i)
      input9_output_select_o == 5'h03 |-> input9_output_number_o == 5'h08;
  endproperty
  a_in9_num: assert property (p_in9_num) else $error("input 9 code 3 not output 8");

  property p_in9_last;
    @(posedge clk_i) disable iff (rst_i)
      input9_output_select_o == IN9_MAX_CODE |-> input9_select_valid_o && input9_output_number_o == 5'h18;
  endproperty
  a_in9_last: assert property (p_in9_last) else $error("last input 9 code not output 24");

  property p_in9_invalid;
    @(posedge clk_i) disable iff (rst_i)
      input9_output_select_o > IN9_MAX_CODE |-> !input9_select_valid_o && input9_output_number_o == 5'h00;
  endproperty
  a_in9_invalid: assert property (p_in9_invalid) else $error("unassigned input 9 code accepted");

  property p_adc_step8;
    @(posedge clk_i) disable iff (rst_i)
      sensor_current_config[ADC_HI:ADC_LO] == 4'h8 |-> sensor_adc_current_ua_o == CUR_HI_BASE;
  endproperty
  a_adc_step8: assert property (p_adc_step8) else $error("adc current code 8 wrong");

  property p_ol_sat;
    @(posedge clk_i) disable iff (rst_i)
      sensor_current_config[OL_HI:OL_LO] >= CUR_SAT_CODE |-> sensor_openload_current_ua_o == CUR_SAT_UA;
  endproperty
  a_ol_sat: assert property (p_ol_sat) else $error("open-load current not saturated");

  property p_oper_lands;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ok && idx == IDX_OPER) |=> key_off_delay_sel_o == $past(wb_dat_i[KDL_HI:KDL_LO]) &&
                                     off_timer_start_source_o == $past(wb_dat_i[SRC_B]);
  endproperty
  a_oper_lands: assert property (p_oper_lands) else $error("operation write lost");

  property p_link_a_lands;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ok && idx == IDX_LINK_A) |=> link_config_a == $past(wb_dat_i[7:0]);
  endproperty
  a_link_a_lands: assert property (p_link_a_lands) else $error("first link write lost");

  property p_link_b_lands;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ok && idx == IDX_LINK_B) |=> link_config_b == $past(wb_dat_i[7:0]);
  endproperty
  a_link_b_lands: assert property (p_link_b_lands) else $error("second link write lost");

  property p_lock_write;
    @(posedge clk_i) disable iff (rst_i)
      (req && wb_we_i && wb_sel_i[0] && idx == IDX_LOCK) |=> lock_o == $past(wb_dat_i[0]);
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock write lost");

  property p_lane_ignored;
    @(posedge clk_i) disable iff (rst_i)
      (req && wb_we_i && !wb_sel_i[0]) |=> $stable(lock) && $stable(operation_config) && $stable(link_config_b);
  endproperty
  a_lane_ignored: assert property (p_lane_ignored) else $error("write without lane 0 stored");

  property p_answer;
    @(posedge clk_i) disable iff (rst_i)
      req |=> (wb_ack_o == $past(hit)) && (wb_err_o == !$past(hit));
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer wrong after request");

  property p_rdata_upper;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");

  property p_misc_reset;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> key_off_delay_sel_o == 2'h0 && !off_timer_start_source_o && !serial_out_push_pull_o &&
                       !upstream_address_mode_o && upstream_fixed_address_o == 4'h0 &&
                       off_timer_threshold_o == 16'h0000 && input9_output_select_o == 5'h00 && !lock_o;
  endproperty
  a_misc_reset: assert property (p_misc_reset) else $error("reset value wrong");

endmodule : scrb_config_bank

//--- logic/scrb_pkg.sv
// package: register map, field layout, reset values and decode tables of the config bank
package scrb_pkg;

  // ==========================================================
  // register indices; the byte address on the bus is the index times four
  localparam logic [9:0] IDX_SENSOR   = 10'h04d;
  localparam logic [9:0] IDX_OPER     = 10'h04e;
  localparam logic [9:0] IDX_LINK_A   = 10'h04f;
  localparam logic [9:0] IDX_LINK_B   = 10'h050;
  localparam logic [9:0] IDX_THR_LO   = 10'h051;
  localparam logic [9:0] IDX_THR_HI   = 10'h052;
  localparam logic [9:0] IDX_IN9      = 10'h053;
  localparam logic [9:0] IDX_LOCK     = 10'h060;
  localparam int         IDX_SHIFT    = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_SENSOR   = 8'h00;
  localparam logic [7:0] RST_OPER     = 8'h09;
  localparam logic [7:0] RST_LINK_A   = 8'ha4;
  localparam logic [7:0] RST_LINK_B   = 8'h0d;
  localparam logic [7:0] RST_THR      = 8'h00;
  localparam logic [7:0] RST_IN9      = 8'h00;

  // ==========================================================
  // writable bit masks; reserved bits stay zero
  localparam logic [7:0] MASK_FULL    = 8'hff;
  localparam logic [7:0] MASK_OPER    = 8'h7f;
  localparam logic [7:0] MASK_IN9     = 8'h1f;

  // ==========================================================
  // field positions
  localparam int ADC_HI = 7;
  localparam int ADC_LO = 4;
  localparam int OL_HI  = 3;
  localparam int OL_LO  = 0;
  localparam int KDL_HI = 6;
  localparam int KDL_LO = 5;
  localparam int SRC_B  = 4;
  localparam int ARS_B  = 3;
  localparam int ARE_B  = 2;
  localparam int PWD_HI = 1;
  localparam int PWD_LO = 0;
  localparam int DIV_HI = 7;
  localparam int DIV_LO = 5;
  localparam int DRV_B  = 4;
  localparam int ADM_B  = 3;
  localparam int PAR_B  = 2;
  localparam int FMT_HI = 1;
  localparam int FMT_LO = 0;
  localparam int FA_HI  = 7;
  localparam int FA_LO  = 4;
  localparam int TOE_B  = 3;
  localparam int LIN_HI = 2;
  localparam int LIN_LO = 1;
  localparam int CAN_B  = 0;
  localparam int IN9_HI = 4;

  // ==========================================================
  // decode constants
  localparam logic [3:0] CUR_SAT_CODE = 4'hb;
  localparam logic [7:0] CUR_SAT_UA   = 8'ha0;
  localparam logic [7:0] CUR_STEP_UA  = 8'h0a;
  localparam logic [7:0] CUR_HI_BASE  = 8'h64;
  localparam logic [7:0] CUR_HI_STEP  = 8'h14;
  localparam logic [4:0] IN9_MAX_CODE = 5'h13;
  localparam logic [4:0] IN9_FIRST    = 5'h05;
  localparam logic [1:0] FMT_NO_ADDR  = 2'h0;
  localparam logic [1:0] LIN_LINK     = 2'h1;
  localparam logic [1:0] LIN_FLASH    = 2'h2;

  typedef enum logic [1:0] {
    SCRB_LIN_RX_ONLY,
    SCRB_LIN_KLINE,
    SCRB_LIN_FLASH
  } scrb_lin_mode_e;

endpackage : scrb_pkg

//--- sim/scrb_config_bank_tb_top.sv
// testbench: configuration bank driven over wishbone, answers checked by a scoreboard
`timescale 1ns/1ps
module scrb_config_bank_tb_top
  import scrb_pkg::*;
();
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  wire logic [31:0] wb_dat_o;
  wire logic        wb_ack_o, wb_err_o, off_timer_start_source_o, afterrun_reset_sel_o, afterrun_enable_o;
  wire logic [7:0]  sensor_adc_current_ua_o, sensor_openload_current_ua_o;
  wire logic [1:0]  key_off_delay_sel_o, power_down_time_sel_o, lin_mode_o;
  wire logic [8:0]  upstream_divide_ratio_o;
  wire logic        serial_out_push_pull_o, upstream_address_mode_o, upstream_even_parity_o;
  wire logic        upstream_with_address_o, tx_timeout_enable_o, can_high_speed_o, input9_select_valid_o, lock_o;
  wire logic [3:0]  upstream_fixed_address_o;
  wire logic [15:0] off_timer_threshold_o;
  wire logic [4:0]  input9_output_select_o, input9_output_number_o;

  // ==========================================================
  // register map model: entry 7 is the lock bit, entry 8 an unmapped hole
  logic [9:0]  idx_tab  [9] = '{IDX_SENSOR, IDX_OPER, IDX_LINK_A, IDX_LINK_B, IDX_THR_LO, IDX_THR_HI,
                                IDX_IN9, IDX_LOCK, 10'h070};
  logic [7:0]  rst_tab  [8] = '{8'h00, 8'h09, 8'ha4, 8'h0d, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  mask_tab [8] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h01};
  logic [8:0]  div_tab  [8] = '{9'h040, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100};
  logic [7:0]  mdl      [8];
  logic [33:0] notes    [$];
  logic [31:0] r;
  int          n_fail, checked, seed, i, k;

  scrb_config_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .sensor_adc_current_ua_o(sensor_adc_current_ua_o),
    .sensor_openload_current_ua_o(sensor_openload_current_ua_o), .key_off_delay_sel_o(key_off_delay_sel_o),
    .off_timer_start_source_o(off_timer_start_source_o), .afterrun_reset_sel_o(afterrun_reset_sel_o),
    .afterrun_enable_o(afterrun_enable_o), .power_down_time_sel_o(power_down_time_sel_o),
    .upstream_divide_ratio_o(upstream_divide_ratio_o), .serial_out_push_pull_o(serial_out_push_pull_o),
    .upstream_address_mode_o(upstream_address_mode_o), .upstream_even_parity_o(upstream_even_parity_o),
    .upstream_with_address_o(upstream_with_address_o), .upstream_fixed_address_o(upstream_fixed_address_o),
    .tx_timeout_enable_o(tx_timeout_enable_o), .lin_mode_o(lin_mode_o), .can_high_speed_o(can_high_speed_o),
    .off_timer_threshold_o(off_timer_threshold_o), .input9_output_select_o(input9_output_select_o),
    .input9_output_number_o(input9_output_number_o), .input9_select_valid_o(input9_select_valid_o),
    .lock_o(lock_o));

  // clock at 40 MHz
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // helpers
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // current ladder in uA for a four-bit code
  function automatic logic [7:0] ua(input logic [3:0] c);
    if (c < 4'h8) return 8'h0a * {4'h0, c + 4'h1};
    if (c < 4'hc) return 8'h64 + 8'h14 * {4'h0, c - 4'h8};
    return 8'ha0;
  endfunction : ua

  task do_reset;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    mdl = rst_tab;
  endtask : do_reset

  // one classic wishbone cycle; the expected answer is noted before the request
  task automatic xfer(input logic w, input int k, input logic [7:0] d, input logic [3:0] s);
    logic [7:0] e;
    e = (k < 8) ? mdl[k] : 8'h00;
    notes.push_back({!w, k == 8, 24'h0, e});
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx_tab[k], 2'b00};
    wdat <= {24'h0, d};
    sel  <= s;
    // wait for the answer; only the watchdog ends a hung cycle
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (w && k < 8 && s[0] && (k == 7 || !mdl[7][0])) mdl[k] = d & mask_tab[k];
  endtask : xfer

  // decoded outputs against the register model
  task check_ports;
    check(sensor_adc_current_ua_o, ua(mdl[0][7:4]));
    check(sensor_openload_current_ua_o, ua(mdl[0][3:0]));
    check(key_off_delay_sel_o, mdl[1][6:5]);
    check(off_timer_start_source_o, mdl[1][4]);
    check(afterrun_reset_sel_o, mdl[1][3]);
    check(afterrun_enable_o, mdl[1][2]);
    check(power_down_time_sel_o, mdl[1][1:0]);
    check(upstream_divide_ratio_o, div_tab[mdl[2][7:5]]);
    check(serial_out_push_pull_o, mdl[2][4]);
    check(upstream_address_mode_o, mdl[2][3]);
    check(upstream_even_parity_o, mdl[2][2]);
    check(upstream_with_address_o, |mdl[2][1:0]);
    check(upstream_fixed_address_o, mdl[3][7:4]);
    check(tx_timeout_enable_o, mdl[3][3]);
    check(lin_mode_o, (mdl[3][2:1] == 2'h3) ? 2'h0 : mdl[3][2:1]);
    check(can_high_speed_o, mdl[3][0]);
    check(off_timer_threshold_o, {mdl[5], mdl[4]});
    check(input9_output_select_o, mdl[6][4:0]);
    check(input9_output_number_o, (mdl[6][4:0] <= 5'h13) ? mdl[6][4:0] + 5'h05 : 5'h00);
    check(input9_select_valid_o, mdl[6][4:0] <= 5'h13);
    check(lock_o, mdl[7][0]);
  endtask : check_ports

  // ==========================================================
  // scoreboard: each answer takes the oldest note
  always @(posedge clk_i) begin
    logic [33:0] nt;
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      if (notes.size() == 0) check(32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        check(wb_err_o, nt[32]);
        check(wb_ack_o, !nt[32]);
        if (nt[33] && !nt[32]) check(wb_dat_o, nt[31:0]);
      end
    end
  end

  // watchdog
  initial begin
    repeat (10000) @(posedge clk_i);
    n_fail++;
    end_of_test;
  end

  // ==========================================================
  // main sequence
  initial begin
    {cyc, stb, we, adr, wdat, sel} = '0;
    rst_i = 1'b1;
    n_fail = 0;
    checked = 0;
    seed = 14146;
    do_reset;
    check_ports;
    for (k = 0; k < 9; k++) xfer(1'b0, k, 8'h00, 4'hf);
    // every code of both current ladders
    for (i = 0; i < 16; i++) begin
      xfer(1'b1, 0, {i[3:0], ~i[3:0]}, 4'hf);
      check_ports;
    end
    // all divider, link and operation codes, reserved bits set
    for (i = 0; i < 8; i++) begin
      xfer(1'b1, 2, {i[2:0], i[1:0], i[2:0]}, 4'hf);
      check_ports;
    end
    for (i = 0; i < 16; i++) begin
      xfer(1'b1, 3, {~i[3:0], i[3:0]}, 4'hf);
      check_ports;
    end
    for (i = 0; i < 32; i++) begin
      xfer(1'b1, 1, {1'b1, i[1:0], i[4:2], i[1:0]}, 4'hf);
      xfer(1'b1, 6, {3'h7, i[4:0]}, 4'hf);
      check_ports;
      xfer(1'b0, 1, 8'h00, 4'hf);
      xfer(1'b0, 6, 8'h00, 4'hf);
    end
    // threshold bytes, then a write without lane 0
    xfer(1'b1, 4, 8'ha5, 4'hf);
    xfer(1'b1, 5, 8'h5a, 4'hf);
    xfer(1'b1, 4, 8'h3c, 4'he);
    xfer(1'b0, 4, 8'h00, 4'hf);
    check_ports;
    // locked bank ignores writes, unlocked again afterwards
    xfer(1'b1, 7, 8'hff, 4'hf);
    for (k = 0; k < 7; k++) begin
      r = $random(seed);
      xfer(1'b1, k, r[7:0], 4'hf);
      xfer(1'b0, k, 8'h00, 4'hf);
    end
    check_ports;
    xfer(1'b1, 7, 8'h00, 4'hf);
    xfer(1'b1, 1, 8'h00, 4'hf);
    check_ports;
    // random traffic over the whole map, holes included
    for (i = 0; i < 80; i++) begin
      r = $random(seed);
      xfer(r[8], int'(r[31:28]) % 9, r[7:0], r[12:9] | {3'h0, r[13]});
      check_ports;
    end
    // second reset in mid-run
    xfer(1'b1, 2, 8'h13, 4'hf);
    do_reset;
    check_ports;
    for (k = 0; k < 8; k++) xfer(1'b0, k, 8'h00, 4'hf);
    repeat (3) @(posedge clk_i);
    end_of_test;
  end

endmodule : scrb_config_bank_tb_top
